// file: design/current_limit_monitor.sv
// Two-channel current input monitor with process and diagnostic interrupts
`timescale 1ns/100ps
`include "limit_mon_consts.svh"
module current_limit_monitor #(
    parameter int CHANNELS = 2
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic [7:0] channel_range_select_0_i,
    input wire logic [7:0] channel_range_select_1_i,
    input wire logic [15:0] channel_upper_limit_0_i,
    input wire logic [15:0] channel_upper_limit_1_i,
    input wire logic [15:0] channel_lower_limit_0_i,
    input wire logic [15:0] channel_lower_limit_1_i,
    input wire logic [7:0] limit_enable_i,
    input wire logic coupler_is_canopen_i,
    input wire logic sample_valid_i,
    input wire logic [15:0] current_ua_0_i,
    input wire logic [15:0] current_ua_1_i,
    input wire logic proc_ack_i,
    input wire logic diag_ack_i,
    input wire logic diag_buf_overflow_i,
    input wire logic comm_error_i,
    output logic [15:0] meas_value_0_o,
    output logic [15:0] meas_value_1_o,
    output logic meas_valid_o,
    output logic [7:0] limit_over_flags_o,
    output logic [7:0] limit_under_flags_o,
    output logic [15:0] event_timestamp_us_o,
    output logic [31:0] ticker_us_o,
    output logic emergency_req_o,
    output logic diag_msg_req_o,
    output logic diag_irq_o,
    output logic [5:0] diag_cause_o,
    output logic param_error_o
);
    import limit_mon_pkg::*;

    localparam logic [3:0] TICK_LAST = 4'(`CYCLES_PER_US - 1);

    logic [7:0] range_sel [CHANNELS];
    logic [15:0] upper_lim [CHANNELS];
    logic [15:0] lower_lim [CHANNELS];
    logic [15:0] current_ua [CHANNELS];
    code_t ch_value [CHANNELS];
    logic [CHANNELS-1:0] ch_valid;
    logic [CHANNELS-1:0] ch_over;
    logic [CHANNELS-1:0] ch_under;
    logic [CHANNELS-1:0] ch_rng_over;
    logic [CHANNELS-1:0] ch_rng_under;
    logic [CHANNELS-1:0] ch_param_err;

    logic [3:0] tick_cnt_q;
    logic [31:0] ticker_q;
    logic [7:0] over_flags_q;
    logic [7:0] under_flags_q;
    logic [15:0] stamp_q;
    logic proc_pending_q;
    logic param_err_q;
    logic proc_event;
    logic proc_lost;
    logic [5:0] diag_event;
    logic [5:0] diag_cause_q;
    logic diag_pending_q;
    logic [7:0] new_over;
    logic [7:0] new_under;

    assign range_sel[0] = channel_range_select_0_i;
    assign range_sel[1] = channel_range_select_1_i;
    assign upper_lim[0] = channel_upper_limit_0_i;
    assign upper_lim[1] = channel_upper_limit_1_i;
    assign lower_lim[0] = channel_lower_limit_0_i;
    assign lower_lim[1] = channel_lower_limit_1_i;
    assign current_ua[0] = current_ua_0_i;
    assign current_ua[1] = current_ua_1_i;

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        channel_checker u_chan (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .clk_en_i(clk_en_i),
            .range_select_i(range_sel[ch]),
            .upper_limit_i(upper_lim[ch]),
            .lower_limit_i(lower_lim[ch]),
            .limit_en_i(limit_enable_i[ch]),
            .sample_valid_i(sample_valid_i),
            .current_ua_i(current_ua[ch]),
            .value_o(ch_value[ch]),
            .value_valid_o(ch_valid[ch]),
            .limit_over_o(ch_over[ch]),
            .limit_under_o(ch_under[ch]),
            .range_over_o(ch_rng_over[ch]),
            .range_under_o(ch_rng_under[ch]),
            .param_err_o(ch_param_err[ch])
        );
    end

    // Microsecond ticker, wraps to zero after all ones
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tick_cnt_q <= 4'h0;
            ticker_q <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (tick_cnt_q == TICK_LAST) begin
                tick_cnt_q <= 4'h0;
                ticker_q <= ticker_q + 32'h0000_0001;
            end else begin
                tick_cnt_q <= tick_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            meas_value_0_o <= 16'h0000;
            meas_value_1_o <= 16'h0000;
            meas_valid_o <= 1'b0;
        end else if (clk_en_i) begin
            meas_value_0_o <= ch_value[0];
            meas_value_1_o <= ch_value[1];
            meas_valid_o <= |ch_valid;
        end
    end

    assign new_over = {6'h00, ch_over[`CH1_BIT], ch_over[`CH0_BIT]};
    assign new_under = {6'h00, ch_under[`CH1_BIT], ch_under[`CH0_BIT]};
    assign proc_event = |{new_over, new_under};
    assign proc_lost = proc_event && proc_pending_q && !proc_ack_i;

    // Process interrupt record; a new event wins over an acknowledge
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            over_flags_q <= 8'h00;
            under_flags_q <= 8'h00;
            stamp_q <= 16'h0000;
            proc_pending_q <= 1'b0;
        end else if (clk_en_i) begin
            if (proc_event && !proc_lost) begin
                over_flags_q <= new_over;
                under_flags_q <= new_under;
                stamp_q <= ticker_q[15:0];
                proc_pending_q <= 1'b1;
            end else if (proc_ack_i) begin
                over_flags_q <= 8'h00;
                under_flags_q <= 8'h00;
                stamp_q <= 16'h0000;
                proc_pending_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            limit_over_flags_o <= 8'h00;
            limit_under_flags_o <= 8'h00;
            event_timestamp_us_o <= 16'h0000;
            ticker_us_o <= 32'h0000_0000;
            emergency_req_o <= 1'b0;
            diag_msg_req_o <= 1'b0;
        end else if (clk_en_i) begin
            limit_over_flags_o <= over_flags_q;
            limit_under_flags_o <= under_flags_q;
            event_timestamp_us_o <= stamp_q;
            ticker_us_o <= ticker_q;
            emergency_req_o <= proc_pending_q && coupler_is_canopen_i;
            diag_msg_req_o <= proc_pending_q && !coupler_is_canopen_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            param_err_q <= 1'b0;
        end else if (clk_en_i) begin
            param_err_q <= |ch_param_err;
        end
    end

    // Cause bits: param, range over, range under, buffer, comm, lost
    assign diag_event = {proc_lost, comm_error_i, diag_buf_overflow_i, |ch_rng_under,
                         |ch_rng_over, (|ch_param_err) && !param_err_q};

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            diag_cause_q <= 6'h00;
            diag_pending_q <= 1'b0;
        end else if (clk_en_i) begin
            if (|diag_event) begin
                diag_cause_q <= (diag_ack_i ? 6'h00 : diag_cause_q) | diag_event;
                diag_pending_q <= 1'b1;
            end else if (diag_ack_i) begin
                diag_cause_q <= 6'h00;
                diag_pending_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            diag_irq_o <= 1'b0;
            diag_cause_o <= 6'h00;
            param_error_o <= 1'b0;
        end else if (clk_en_i) begin
            diag_irq_o <= diag_pending_q;
            diag_cause_o <= diag_cause_q;
            param_error_o <= param_err_q;
        end
    end
endmodule : current_limit_monitor

// file: design/limit_mon_consts.svh
// Constants of the current-input range and limit monitor
// What this block does
// - Range select all-ones switches the channel off, no measurement produced.
// - First format codes: full scale 27648, over 7EFFh, under ED00h.
// - Second format codes: full scale 16384, over 5000h, under F333h.
// - Limits outside nominal range give a parameterization error.
// - Upper limit 7FFFh or lower limit 8000h disables that check.
// - Monitoring on and value beyond an active limit starts a process interrupt.
// - Param error, range over/under, buffer, comm, lost: diagnostic interrupts only.
// - Limit over/underflow raise only process interrupts, gated by parameters.
// - Overflow byte: bit 0 channel 0, bit 1 channel 1, rest reserved.
// - Interrupt data: overflow byte, underflow byte, two-byte microsecond ticker.
// - Emergency message for CANopen, diagnostics message otherwise.
// - Underflow byte: bit 0 channel 0, bit 1 channel 1, rest reserved.
// - Free 32-bit microsecond counter from zero, wraps, stamps events.
// - Monitoring enable byte: bit 0 channel 0, bit 1 channel 1.
`ifndef LIMIT_MON_CONSTS_SVH
`define LIMIT_MON_CONSTS_SVH

`define FN_OFF 8'hff
`define FN_FMT1_0_20 8'h31
`define FN_FMT1_4_20 8'h30
`define FN_FMT2_0_20 8'h41
`define FN_FMT2_4_20 8'h40

`define FMT1_NOMINAL 16'sh6c00
`define FMT1_OVER 16'sh7eff
`define FMT1_UNDER 16'shed00
`define FMT2_NOMINAL 16'sh4000
`define FMT2_OVER 16'sh5000
`define FMT2_UNDER 16'shf333

`define LIMIT_UPPER_OFF 16'h7fff
`define LIMIT_LOWER_OFF 16'h8000

// Zero point in microamps
`define ZERO_0MA 18'sh00000
`define ZERO_4MA 18'sh00fa0

// Scale factors in units of 2^-14 code per microamp
`define SCALE_SHIFT 14
`define MUL_FMT1_0_20 17'sh05879
`define MUL_FMT1_4_20 17'sh06e98
`define MUL_FMT2_0_20 17'sh0346e
`define MUL_FMT2_4_20 17'sh04189

`define CH0_BIT 0
`define CH1_BIT 1

`define US_PERIOD_NS 1000
`define CLK_PERIOD_NS 100
`define CYCLES_PER_US (`US_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// file: design/limit_mon_pkg.sv
// Types shared by the monitor modules
package limit_mon_pkg;
    typedef enum logic [1:0] {
        FMT_OFF = 2'b00,
        FMT_ONE = 2'b01,
        FMT_TWO = 2'b10,
        FMT_BAD = 2'b11
    } fmt_t;

    typedef logic [15:0] code_t;
endpackage : limit_mon_pkg

// file: design/channel_checker.sv
// One channel: range conversion, range and limit checks
`timescale 1ns/100ps
`include "limit_mon_consts.svh"
module channel_checker (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic [7:0] range_select_i,
    input wire logic [15:0] upper_limit_i,
    input wire logic [15:0] lower_limit_i,
    input wire logic limit_en_i,
    input wire logic sample_valid_i,
    input wire logic [15:0] current_ua_i,
    output logic [15:0] value_o,
    output logic value_valid_o,
    output logic limit_over_o,
    output logic limit_under_o,
    output logic range_over_o,
    output logic range_under_o,
    output logic param_err_o
);
    import limit_mon_pkg::*;

    fmt_t fmt;
    logic signed [17:0] zero;
    logic signed [16:0] mul;
    logic signed [15:0] nominal;
    logic signed [15:0] over_code;
    logic signed [15:0] under_code;
    logic signed [17:0] diff;
    logic signed [34:0] prod;
    logic signed [20:0] scaled;
    logic signed [15:0] value_d;
    logic rng_over_d;
    logic rng_under_d;
    logic ul_active;
    logic ll_active;
    logic param_err_d;

    always_comb begin
        fmt = FMT_BAD;
        zero = `ZERO_0MA;
        mul = `MUL_FMT1_0_20;
        unique case (range_select_i)
            `FN_OFF: fmt = FMT_OFF;
            `FN_FMT1_0_20: begin
                fmt = FMT_ONE;
            end
            `FN_FMT1_4_20: begin
                fmt = FMT_ONE;
                zero = `ZERO_4MA;
                mul = `MUL_FMT1_4_20;
            end
            `FN_FMT2_0_20: begin
                fmt = FMT_TWO;
                mul = `MUL_FMT2_0_20;
            end
            `FN_FMT2_4_20: begin
                fmt = FMT_TWO;
                zero = `ZERO_4MA;
                mul = `MUL_FMT2_4_20;
            end
            default: fmt = FMT_BAD;
        endcase
    end

    assign nominal = (fmt == FMT_TWO) ? `FMT2_NOMINAL : `FMT1_NOMINAL;
    assign over_code = (fmt == FMT_TWO) ? `FMT2_OVER : `FMT1_OVER;
    assign under_code = (fmt == FMT_TWO) ? `FMT2_UNDER : `FMT1_UNDER;

    // Measured current to digital code, clipped to the over/underrange ends
    assign diff = $signed({2'b00, current_ua_i}) - zero;
    assign prod = diff * mul;
    assign scaled = prod[`SCALE_SHIFT +: 21];

    always_comb begin
        rng_over_d = 1'b0;
        rng_under_d = 1'b0;
        value_d = scaled[15:0];
        if (scaled > 21'(over_code)) begin
            value_d = over_code;
            rng_over_d = 1'b1;
        end else if (scaled < 21'(under_code)) begin
            value_d = under_code;
            rng_under_d = 1'b1;
        end
    end

    assign ul_active = (upper_limit_i != `LIMIT_UPPER_OFF);
    assign ll_active = (lower_limit_i != `LIMIT_LOWER_OFF);

    // Limits must lie in 0 .. nominal full scale
    always_comb begin
        param_err_d = 1'b0;
        if (fmt == FMT_BAD) begin
            param_err_d = 1'b1;
        end else if (fmt != FMT_OFF) begin
            if (ul_active && ($signed(upper_limit_i) < 0 || $signed(upper_limit_i) > nominal)) begin
                param_err_d = 1'b1;
            end
            if (ll_active && ($signed(lower_limit_i) < 0 || $signed(lower_limit_i) > nominal)) begin
                param_err_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            param_err_o <= 1'b0;
        end else if (clk_en_i) begin
            param_err_o <= param_err_d;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            value_o <= 16'h0000;
            value_valid_o <= 1'b0;
            limit_over_o <= 1'b0;
            limit_under_o <= 1'b0;
            range_over_o <= 1'b0;
            range_under_o <= 1'b0;
        end else if (clk_en_i) begin
            value_valid_o <= 1'b0;
            limit_over_o <= 1'b0;
            limit_under_o <= 1'b0;
            range_over_o <= 1'b0;
            range_under_o <= 1'b0;
            if (sample_valid_i && fmt != FMT_OFF && fmt != FMT_BAD) begin
                value_o <= value_d;
                value_valid_o <= 1'b1;
                range_over_o <= rng_over_d;
                range_under_o <= rng_under_d;
                if (limit_en_i && !param_err_d) begin
                    limit_over_o <= ul_active && (value_d > $signed(upper_limit_i));
                    limit_under_o <= ll_active && (value_d < $signed(lower_limit_i));
                end
            end
        end
    end
endmodule : channel_checker

// file: tb/current_limit_monitor_chk.sv
// Port assertions for the two-channel current limit monitor
`timescale 1ns/100ps
module current_limit_monitor_chk (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic param_error_o,
    input wire logic diag_irq_o,
    input wire logic emergency_req_o,
    input wire logic diag_msg_req_o,
    input wire logic [7:0] limit_over_flags_o,
    input wire logic [7:0] limit_under_flags_o,
    input wire logic [31:0] ticker_us_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire any_flag = |{limit_over_flags_o, limit_under_flags_o};
    wire any_req = emergency_req_o | diag_msg_req_o;

    a_over_rsvd_zero: assert property (limit_over_flags_o[7:2] == 6'h00)
        else $error("overflow reserved bits set");
    a_under_rsvd_zero: assert property (limit_under_flags_o[7:2] == 6'h00)
        else $error("underflow reserved bits set");
    a_req_one_path: assert property (!(emergency_req_o && diag_msg_req_o))
        else $error("both message requests high");
    a_req_has_flag: assert property (any_req |-> any_flag)
        else $error("request without limit flag");
    a_flag_has_req: assert property (any_flag |-> any_req)
        else $error("limit flag without request");
    a_ticker_step: assert property (ticker_us_o == $past(ticker_us_o) ||
        ticker_us_o == $past(ticker_us_o) + 32'h1)
        else $error("ticker jumped");
    a_ticker_pace: assert property ($changed(ticker_us_o) |=> $stable(ticker_us_o)[*8])
        else $error("ticker too fast");
    a_param_to_diag: assert property ($rose(param_error_o) |-> ##[0:3] diag_irq_o)
        else $error("param error without diag interrupt");

    c_emergency: cover property ($rose(emergency_req_o));
    c_diag_msg: cover property ($rose(diag_msg_req_o));
    c_param: cover property ($rose(param_error_o));
endmodule : current_limit_monitor_chk

bind current_limit_monitor current_limit_monitor_chk current_limit_monitor_chk_i (
    .sys_clk_i, .rst_i, .param_error_o, .diag_irq_o, .emergency_req_o,
    .diag_msg_req_o, .limit_over_flags_o, .limit_under_flags_o, .ticker_us_o
);

// file: tb/coupler_model.sv
// Bus coupler that acknowledges process interrupt requests
`timescale 1ns/100ps
module coupler_model #(
    parameter int DELAY = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic emergency_req_i,
    input wire logic diag_msg_req_i,
    output logic proc_ack_o
);
    int wait_cnt = 0;
    logic done = 1'b0;
    initial proc_ack_o = 1'b0;
    // One acknowledge per request, whichever message carries it
    always @(posedge sys_clk_i) begin
        #1;
        if (rst_i || !(emergency_req_i || diag_msg_req_i)) begin
            wait_cnt = 0;
            done = 1'b0;
            proc_ack_o = 1'b0;
        end else if (!done && wait_cnt >= DELAY) begin
            proc_ack_o = 1'b1;
            done = 1'b1;
        end else begin
            proc_ack_o = 1'b0;
            wait_cnt++;
        end
    end
endmodule : coupler_model

// file: tb/current_limit_monitor_tb.sv
// Self-checking bench for the two-channel current limit monitor
`timescale 1ns/100ps
module current_limit_monitor_tb;
    import limit_mon_pkg::*;
    localparam logic [31:0] CODES = 32'h31304140;
    localparam logic [63:0] FS = 64'h6c006c0040004000;
    localparam logic [63:0] OVR = 64'h7eff7eff50005000;
    localparam logic [63:0] Q4 = 64'h159a00000ccd0000;
    localparam logic [63:0] ZER = 64'h0000ed000000f333;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic canopen = 1'b0;
    logic sv = 1'b0;
    logic dack = 1'b0;
    logic clk_en = 1'b1;
    logic dbuf = 1'b0;
    logic cerr = 1'b0;
    logic [7:0] fn0 = 8'h31;
    logic [7:0] fn1 = 8'hff;
    logic [7:0] len = 8'h00;
    code_t ul0 = 16'h7fff;
    code_t ul1 = 16'h7fff;
    code_t ll0 = 16'h8000;
    code_t ll1 = 16'h8000;
    code_t cur0 = 16'h0000;
    code_t cur1 = 16'h0000;
    code_t mv0, mv1, ts;
    logic mvld, emr, dmr, dirq, perr, pack;
    logic [7:0] ovf, unf;
    logic [31:0] tick;
    logic [5:0] dcause;
    int bad_count = 0;
    int comparisons = 0;

    always #50 sys_clk_i = ~sys_clk_i;

    current_limit_monitor current_limit_monitor_i (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en),
        .channel_range_select_0_i(fn0), .channel_range_select_1_i(fn1),
        .channel_upper_limit_0_i(ul0), .channel_upper_limit_1_i(ul1),
        .channel_lower_limit_0_i(ll0), .channel_lower_limit_1_i(ll1),
        .limit_enable_i(len), .coupler_is_canopen_i(canopen), .sample_valid_i(sv),
        .current_ua_0_i(cur0), .current_ua_1_i(cur1), .proc_ack_i(pack),
        .diag_ack_i(dack), .diag_buf_overflow_i(dbuf), .comm_error_i(cerr),
        .meas_value_0_o(mv0), .meas_value_1_o(mv1), .meas_valid_o(mvld),
        .limit_over_flags_o(ovf), .limit_under_flags_o(unf),
        .event_timestamp_us_o(ts), .ticker_us_o(tick), .emergency_req_o(emr),
        .diag_msg_req_o(dmr), .diag_irq_o(dirq), .diag_cause_o(dcause),
        .param_error_o(perr)
    );

    coupler_model coupler_model_i (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .emergency_req_i(emr),
        .diag_msg_req_i(dmr), .proc_ack_o(pack)
    );

    task step(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            #1;
        end
    endtask : step

    task chk(input string what, input code_t exp, input code_t got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Conversion may be off by one code
    task chk_near(input string what, input code_t exp, input code_t got);
        code_t d;
        d = got - exp;
        comparisons++;
        if (!(d === 16'h0 || d === 16'h1 || d === 16'hffff)) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_near

    task sample(input code_t a, input code_t b);
        cur0 = a;
        cur1 = b;
        sv = 1'b1;
        step(1);
        sv = 1'b0;
        step(3);
    endtask : sample

    task wait_clear;
        int n;
        n = 0;
        while ((emr | dmr) !== 1'b0 && n < 40) begin
            step(1);
            n++;
        end
        chk("request cleared", 16'h0, {14'h0, emr, dmr});
        chk("flags after ack", 16'h0, {ovf, unf});
    endtask : wait_clear

    task diag_clear;
        dack = 1'b1;
        step(1);
        dack = 1'b0;
        step(2);
        chk("diag cleared", 16'h0, {9'h0, dirq, dcause});
    endtask : diag_clear

    task t_reset;
        chk("ticker", 16'h0, tick[15:0]);
        chk("idle outputs", 16'h0, {4'h0, emr, dmr, dirq, perr, ovf});
        $display("t_reset done");
    endtask : t_reset

    task t_codes;
        for (int i = 0; i < 4; i++) begin
            fn0 = CODES[31-8*i -: 8];
            sample(16'd20000, 16'h0);
            chk_near("full scale", FS[63-16*i -: 16], mv0);
            sample(16'd30000, 16'h0);
            chk("over clip", OVR[63-16*i -: 16], mv0);
            chk("range over", 16'h1, {15'h0, dcause[1]});
            chk("no proc irq", 16'h0, {ovf, unf});
            sample(16'd4000, 16'h0);
            chk_near("at 4 mA", Q4[63-16*i -: 16], mv0);
            sample(16'h0, 16'h0);
            chk("at 0 mA", ZER[63-16*i -: 16], mv0);
        end
        chk("diag irq", 16'h1, {15'h0, dirq});
        chk("range causes", 16'h0006, {10'h0, dcause});
        diag_clear;
        $display("t_codes done");
    endtask : t_codes

    task t_over;
        fn0 = 8'h31;
        ul0 = 16'h1000;
        len = 8'h01;
        canopen = 1'b1;
        sample(16'd20000, 16'h0);
        chk("over flags", 16'h0100, {ovf, unf});
        chk("emergency", 16'h2, {14'h0, emr, dmr});
        chk_near("stamp", tick[15:0], ts);
        wait_clear;
        $display("t_over done");
    endtask : t_over

    task t_under;
        canopen = 1'b0;
        fn1 = 8'h40;
        ll1 = 16'h0100;
        len = 8'h02;
        sample(16'd20000, 16'd4000);
        chk_near("ch1 at 4 mA", 16'h0, mv1);
        chk("under flags", 16'h0002, {ovf, unf});
        chk("diag message", 16'h1, {14'h0, emr, dmr});
        wait_clear;
        $display("t_under done");
    endtask : t_under

    task t_off;
        fn0 = 8'hff;
        len = 8'h03;
        sample(16'd30000, 16'd20000);
        chk_near("held value", 16'h6c00, mv0);
        chk_near("ch1 value", 16'h4000, mv1);
        chk("off no flags", 16'h0, {ovf, unf});
        $display("t_off done");
    endtask : t_off

    task t_param;
        fn0 = 8'h31;
        ul0 = 16'h7000;
        len = 8'h01;
        step(3);
        chk("param error", 16'h1, {15'h0, perr});
        sample(16'd30000, 16'd20000);
        chk("skip on error", 16'h0, {ovf, unf});
        chk("param cause", 16'h1, {15'h0, dcause[0]});
        ul0 = 16'h7fff;
        step(3);
        chk("param ok", 16'h0, {15'h0, perr});
        sample(16'd30000, 16'd20000);
        chk("upper off", 16'h0, {ovf, unf});
        diag_clear;
        $display("t_param done");
    endtask : t_param

    task t_freeze;
        code_t t0;
        t0 = tick[15:0];
        clk_en = 1'b0;
        step(25);
        chk("frozen ticker", t0, tick[15:0]);
        clk_en = 1'b1;
        step(10);
        chk("ticker pace", t0 + 16'h1, tick[15:0]);
        cur0 = 16'd4000;
        cur1 = 16'd4000;
        sv = 1'b1;
        step(1);
        sv = 1'b0;
        step(1);
        chk("valid pulse", 16'h1, {15'h0, mvld});
        step(1);
        chk("valid ends", 16'h0, {15'h0, mvld});
        fn0 = 8'hff;
        fn1 = 8'hff;
        sv = 1'b1;
        step(1);
        sv = 1'b0;
        step(1);
        chk("off no valid", 16'h0, {15'h0, mvld});
        fn0 = 8'h31;
        fn1 = 8'h40;
        step(3);
        $display("t_freeze done");
    endtask : t_freeze

    task t_diag_events;
        dbuf = 1'b1;
        step(1);
        dbuf = 1'b0;
        cerr = 1'b1;
        step(1);
        cerr = 1'b0;
        step(2);
        chk("buf comm causes", 16'h0018, {10'h0, dcause});
        chk("diag not proc", 16'h1, {13'h0, emr, dmr, dirq});
        diag_clear;
        $display("t_diag_events done");
    endtask : t_diag_events

    task t_lost;
        ul0 = 16'h1000;
        canopen = 1'b1;
        sample(16'd20000, 16'd4000);
        sample(16'd20000, 16'd4000);
        wait_clear;
        chk("lost cause", 16'h0020, {10'h0, dcause});
        diag_clear;
        $display("t_lost done");
    endtask : t_lost

    task finish_test;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    initial begin
        #300000;
        bad_count++;
        finish_test;
    end

    initial begin
        step(5);
        rst_i = 1'b0;
        step(1);
        t_reset;
        t_codes;
        t_over;
        t_under;
        t_off;
        t_param;
        t_freeze;
        t_diag_events;
        t_lost;
        finish_test;
    end
endmodule : current_limit_monitor_tb
